/* rtl/fsp_top.sv */
/*
 Sector protection engine: persistent and dynamic sector bits, the lock,
 mode selection and hidden password, reached as an APB slave.
 Assumes one 200 MHz clock; rst_n_in is power-on reset.
*/
module fsp_top #(
   parameter int SECTORS = 256,
   parameter int TPP_CYC = fsp_pkg::FSP_TPP_CYC,
   parameter int TSE_CYC = fsp_pkg::FSP_TSE_CYC,
   parameter int TUNLK_CYC = fsp_pkg::FSP_TUNLK_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [SECTORS-1:0] sector_protected_out,
   output logic busy_out
);
   import fsp_pkg::*;

   localparam int SW = $clog2(SECTORS);

   // Registers
   logic [SECTORS-1:0] pbit_q;
   logic [SECTORS-1:0] dbit_q;
   logic [SECTORS-1:0] range_q;
   logic [SECTORS-1:0] prot_q;
   logic lock_q;
   logic [2:0] cfg_q;
   logic [63:0] pw_q;
   logic [63:0] pwin_q;
   logic wel_q;
   logic perr_q;
   logic rdata_q;
   logic unlk_gap_q;
   logic [31:0] cnt_q;
   logic [31:0] gap_q;
   fsp_cmd_t cmd_q;
   logic [1:0] mbits_q;
   fsp_state_t st_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic busy_q;
   logic hwrst_q;

   // Decode
   wire setup_w = psel_in & ~penable_in;
   wire wr_w = setup_w & pwrite_in;
   wire rd_w = setup_w & ~pwrite_in;
   wire cmd_wr_w = wr_w & (paddr_in == FSP_CMD_OFS);
   wire [3:0] op_w = pwdata_in[3:0];
   wire idle_w = (st_q == FSP_IDLE);
   wire mapped_w = (paddr_in[1:0] == 2'b00) && (paddr_in <= FSP_PROT_OFS);
   wire [1:0] mode_w = cfg_q[FSP_CFG_MHI:FSP_CFG_MLO];
   wire pass_mode_w = (mode_w == FSP_MODE_PASS);
   wire mode_set_w = (mode_w != FSP_MODE_NONE);
   wire [SW-1:0] sidx_w = cmd_q.sector[SW-1:0];
   wire nv_ok_w = wel_q;
   wire pw_match_w = (pwin_q == pw_q);

   // Accepted command starts; write enable and resets act at once
   wire start_w = cmd_wr_w & idle_w;
   // Reset commands skip the idle check, else a stuck failure never clears
   wire hw_op_w = cmd_wr_w & (op_w == FSP_OP_HWRST);
   wire rst_op_w = hw_op_w | (cmd_wr_w & (op_w == FSP_OP_SWRST));
   fsp_cmd_t new_cmd_w;
   assign new_cmd_w.op = op_w;
   assign new_cmd_w.data = pwdata_in[4];
   assign new_cmd_w.sector = pwdata_in[31:16];

   // Protection: per-sector bits combined with block range
   wire [SECTORS-1:0] prot_w = ~(pbit_q & dbit_q) | range_q;

   logic [31:0] rd_mux_w;
   always_comb begin
      rd_mux_w = 32'h0000_0000;
      case (paddr_in)
         FSP_STAT_OFS: begin
            rd_mux_w[FSP_ST_BUSY] = busy_q;
            rd_mux_w[FSP_ST_WEL] = wel_q;
            rd_mux_w[FSP_ST_PERR] = perr_q;
            rd_mux_w[FSP_ST_LOCK] = lock_q;
         end
         FSP_CFG_OFS: rd_mux_w[2:0] = cfg_q;
         FSP_RDATA_OFS: rd_mux_w[0] = rdata_q;
         FSP_CMD_OFS: rd_mux_w = {cmd_q.sector, 11'h000, cmd_q.data, cmd_q.op};
         default: rd_mux_w = 32'h0000_0000;
      endcase
   end

   // Next-state decisions for the accepted command
   logic [31:0] dur_w;
   logic fail_w;
   always_comb begin
      dur_w = 32'(FSP_TRD_CYC);
      fail_w = 1'b0;
      case (new_cmd_w.op)
         FSP_OP_PBPROG: begin
            dur_w = 32'(TPP_CYC);
            fail_w = ~lock_q | ~nv_ok_w;
         end
         FSP_OP_PBERASE: begin
            dur_w = 32'(TSE_CYC);
            fail_w = ~lock_q | ~nv_ok_w;
         end
         FSP_OP_CFGPROG: begin
            dur_w = 32'(TPP_CYC);
            fail_w = mode_set_w | ~nv_ok_w | (pwdata_in[5:4] == 2'b00);
         end
         FSP_OP_PWPROG: begin
            dur_w = 32'(TPP_CYC);
            fail_w = mode_set_w | ~nv_ok_w;
         end
         FSP_OP_UNLOCK: begin
            dur_w = 32'(TPP_CYC);
            fail_w = ~pass_mode_w | (pwin_q != pw_q);
         end
         default: begin
            dur_w = 32'(FSP_TRD_CYC);
            fail_w = 1'b0;
         end
      endcase
   end

   // Dynamic bits: volatile, cleared to unprotected on any reset
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dbit_q <= '1;
      end else if (rst_op_w) begin
         dbit_q <= '1;
      end else if (start_w && op_w == FSP_OP_DBWRITE) begin
         dbit_q[pwdata_in[16 +: SW]] <= pwdata_in[4];
      end
   end

   // Block-range input register
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         range_q <= '0;
      end else if (wr_w && paddr_in == FSP_RANGE_OFS) begin
         range_q[pwdata_in[16 +: SW]] <= pwdata_in[0];
      end
   end

   // Password staging for unlock
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwin_q <= '0;
      end else if (wr_w && paddr_in == FSP_PWLO_OFS) begin
         pwin_q[31:0] <= pwdata_in;
      end else if (wr_w && paddr_in == FSP_PWHI_OFS) begin
         pwin_q[63:32] <= pwdata_in;
      end
   end

   // Lock: reset value depends on mode; software reset leaves it alone
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lock_q <= 1'b1;
         hwrst_q <= 1'b0;
      end else begin
         hwrst_q <= hw_op_w;
         if (hwrst_q) begin
            lock_q <= ~pass_mode_w;
         end else if (start_w && op_w == FSP_OP_LOCKCLR) begin
            lock_q <= 1'b0;
         end else if (st_q == FSP_DONE && cmd_q.op == FSP_OP_UNLOCK && pass_mode_w
                      && pw_match_w) begin
            lock_q <= 1'b1;
         end
      end
   end

   // Command engine
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= FSP_IDLE;
         cmd_q <= '0;
         mbits_q <= 2'h3;
         cnt_q <= '0;
         gap_q <= '0;
         unlk_gap_q <= 1'b0;
         perr_q <= 1'b0;
         wel_q <= 1'b0;
         busy_q <= 1'b0;
         pbit_q <= '1;
         cfg_q <= FSP_CFG_RST;
         pw_q <= FSP_PW_RST;
         rdata_q <= 1'b1;
      end else begin
         if (gap_q != 32'h0000_0000) begin
            gap_q <= gap_q - 32'h0000_0001;
         end
         case (st_q)
            FSP_IDLE: begin
               if (start_w) begin
                  cmd_q <= new_cmd_w;
                  mbits_q <= pwdata_in[5:4];
                  if (op_w == FSP_OP_WR_ENABLE) begin
                     wel_q <= 1'b1;
                  end else if (op_w == FSP_OP_UNLOCK && gap_q != 32'h0000_0000) begin
                     perr_q <= 1'b1;
                  end else if (op_w != FSP_OP_DBWRITE && op_w != FSP_OP_LOCKCLR) begin
                     st_q <= FSP_WAIT;
                     busy_q <= 1'b1;
                     cnt_q <= dur_w;
                     perr_q <= fail_w;
                     unlk_gap_q <= (op_w == FSP_OP_UNLOCK) & fail_w;
                  end
               end
            end
            FSP_WAIT: begin
               // Failed writes keep busy high until a reset command
               if (perr_q && cmd_q.op != FSP_OP_UNLOCK) begin
                  st_q <= FSP_WAIT;
               end else if (cnt_q <= 32'h0000_0001) begin
                  st_q <= FSP_DONE;
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            FSP_DONE: begin
               st_q <= FSP_IDLE;
               wel_q <= 1'b0;
               if (!perr_q) begin
                  busy_q <= 1'b0;
                  case (cmd_q.op)
                     FSP_OP_PBPROG: pbit_q[sidx_w] <= 1'b0;
                     FSP_OP_PBERASE: pbit_q <= '1;
                     FSP_OP_PBREAD: rdata_q <= pbit_q[sidx_w];
                     FSP_OP_CFGPROG: cfg_q <= {mbits_q, 1'b1};
                     FSP_OP_PWPROG: pw_q <= {pwin_q};
                     default: busy_q <= 1'b0;
                  endcase
               end else if (cmd_q.op == FSP_OP_UNLOCK) begin
                  st_q <= FSP_IDLE;
                  if (unlk_gap_q) begin
                     gap_q <= 32'(TUNLK_CYC);
                  end
               end
            end
            default: st_q <= FSP_IDLE;
         endcase
         // Any reset command clears a stuck failure, busy or not
         if (rst_op_w) begin
            st_q <= FSP_IDLE;
            busy_q <= 1'b0;
            perr_q <= 1'b0;
            wel_q <= 1'b0;
         end
      end
   end

   // APB answer: no wait state; ready and response registered from the setup phase
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prot_q <= '0;
      end else begin
         prot_q <= prot_w;
         pready_q <= setup_w;
         pslverr_q <= setup_w & ~mapped_w;
         if (rd_w) begin
            prdata_q <= rd_mux_w;
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign sector_protected_out = prot_q;
   assign busy_out = busy_q;
endmodule // fsp_top

/* shared/fsp_pkg.sv */
/*
 Package for the flash sector protection block: APB register map, field
 positions, reset values, command codes, timing counts and carrier types.
 Assumes a 200 MHz core clock and a 32-bit APB master.
*/
package fsp_pkg;
   // Register byte offsets
   localparam logic [7:0] FSP_CMD_OFS = 8'h00;
   localparam logic [7:0] FSP_ARG_OFS = 8'h04;
   localparam logic [7:0] FSP_PWLO_OFS = 8'h08;
   localparam logic [7:0] FSP_PWHI_OFS = 8'h0C;
   localparam logic [7:0] FSP_STAT_OFS = 8'h10;
   localparam logic [7:0] FSP_CFG_OFS = 8'h14;
   localparam logic [7:0] FSP_RDATA_OFS = 8'h18;
   localparam logic [7:0] FSP_RANGE_OFS = 8'h1C;
   localparam logic [7:0] FSP_PROT_OFS = 8'h20;
   // Command codes written to CMD[3:0]
   localparam logic [3:0] FSP_OP_WR_ENABLE = 4'h1;
   localparam logic [3:0] FSP_OP_PBPROG = 4'h2;
   localparam logic [3:0] FSP_OP_PBERASE = 4'h3;
   localparam logic [3:0] FSP_OP_PBREAD = 4'h4;
   localparam logic [3:0] FSP_OP_DBWRITE = 4'h5;
   localparam logic [3:0] FSP_OP_LOCKCLR = 4'h6;
   localparam logic [3:0] FSP_OP_UNLOCK = 4'h7;
   localparam logic [3:0] FSP_OP_CFGPROG = 4'h8;
   localparam logic [3:0] FSP_OP_PWPROG = 4'h9;
   localparam logic [3:0] FSP_OP_SWRST = 4'hA;
   localparam logic [3:0] FSP_OP_HWRST = 4'hB;
   // Status bits
   localparam int FSP_ST_BUSY = 0;
   localparam int FSP_ST_WEL = 1;
   localparam int FSP_ST_PERR = 2;
   localparam int FSP_ST_LOCK = 3;
   // Config register mode bits
   localparam int FSP_CFG_MLO = 1;
   localparam int FSP_CFG_MHI = 2;
   localparam logic [1:0] FSP_MODE_NONE = 2'h3;
   localparam logic [1:0] FSP_MODE_PERS = 2'h2;
   localparam logic [1:0] FSP_MODE_PASS = 2'h1;
   localparam logic [2:0] FSP_CFG_RST = 3'h7;
   // Timing
   localparam int FSP_CLK_MHZ = 200;
   localparam int FSP_TPP_US = 250;
   localparam int FSP_TSE_US = 500;
   localparam int FSP_TUNLK_US = 100;
   localparam int FSP_TPP_CYC = FSP_TPP_US * FSP_CLK_MHZ;
   localparam int FSP_TSE_CYC = FSP_TSE_US * FSP_CLK_MHZ;
   localparam int FSP_TUNLK_CYC = FSP_TUNLK_US * FSP_CLK_MHZ;
   localparam int FSP_TRD_CYC = 2;
   localparam logic [63:0] FSP_PW_RST = 64'hFFFF_FFFF_FFFF_FFFF;

   typedef enum logic [1:0] {
      FSP_IDLE = 2'b00,
      FSP_WAIT = 2'b01,
      FSP_DONE = 2'b10
   } fsp_state_t;

   typedef struct packed {
      logic [3:0] op;
      logic data;
      logic [15:0] sector;
   } fsp_cmd_t;
endpackage

/* test/fsp_host.sv */
/* APB master model standing in for the host controller.
   Assumes a slave that answers with pready in the access phase. */
module fsp_host (
   input wire logic clk_in,
   input wire logic pready_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0000_0000;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= wr;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do @(posedge clk_in); while (pready_in !== 1'b1 && ++n < 50);
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released lines must not keep looking valid
      paddr_out <= ~a;
      pwdata_out <= ~d;
   endtask
endmodule // fsp_host

/* test/fsp_top_asserts.sv */
/* Checker for the sector protection block, watching its top ports only.
   Assumes one clock and the active-low asynchronous reset. */
module fsp_top_asserts import fsp_pkg::*; #(
   parameter int SECTORS = 256
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [SECTORS-1:0] sector_protected_out,
   input wire logic busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire setup_w = psel_in && !penable_in;
   wire dyn_clr_w = setup_w && pwrite_in && paddr_in == FSP_CMD_OFS &&
      pwdata_in[4:0] == {1'b0, FSP_OP_DBWRITE} && !busy_out;
   ready_after_setup_a: assert property (setup_w |=> pready_out)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   ready_access_a: assert property (pready_out |-> psel_in && penable_in)
      else $error("ready outside access phase");
   unmapped_err_a: assert property (pready_out && paddr_in > 8'h20 |-> pslverr_out)
      else $error("unmapped address not flagged");
   mapped_ok_a: assert property (pready_out && paddr_in <= 8'h20 && paddr_in[1:0] == 2'h0
      |-> !pslverr_out) else $error("mapped address flagged");
   unmapped_zero_a: assert property (pready_out && pslverr_out && !pwrite_in
      |-> prdata_out == 32'h0000_0000) else $error("unmapped read not zero");
   dyn_protect_a: assert property (dyn_clr_w |-> ##[1:3] |sector_protected_out)
      else $error("dynamic clear left all unprotected");
   reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |->
      sector_protected_out == '0 && !busy_out && !pready_out) else $error("reset state wrong");
   busy_hold_a: assert property ($rose(busy_out) |=> busy_out)
      else $error("busy pulse too short");
   dyn_c: cover property (dyn_clr_w);
   err_c: cover property (pready_out && pslverr_out);
   busy_c: cover property ($rose(busy_out));
endmodule // fsp_top_asserts

/* test/tb.sv */
/* Self-checking bench for the sector protection block.
   Assumes the host model drives APB and short timing parameters. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, busy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [255:0] prot;
   logic [63:0] expq[$];
   logic [63:0] pw, n;
   int fail_count = 0;
   int compares = 0;
   int s;
   fsp_top #(.SECTORS(256), .TPP_CYC(20), .TSE_CYC(40), .TUNLK_CYC(30)) u_fsp_top (
      .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sector_protected_out(prot),
      .busy_out(busy));
   fsp_host u_fsp_host (.clk_in(clk), .pready_in(pready), .psel_out(psel),
      .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_fsp_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      expq.push_back({m, e});
      u_fsp_host.xfer(1'b0, a, 32'h0000_0000);
   endtask
   // Bounded wait: failed operations leave busy standing
   task automatic cmd(input logic [3:0] op, input logic [1:0] m, input int sec);
      wr(FSP_CMD_OFS, {sec[15:0], 10'h000, m, op});
      repeat (3) @(posedge clk);
      for (int i = 0; i < 120 && busy === 1'b1; i++) @(posedge clk);
   endtask
   task automatic pchk(input int i, input logic e);
      repeat (2) @(posedge clk);
      check("prot", {31'h0, prot[i]}, {31'h0, e});
   endtask
   always @(posedge clk) begin
      if (pready === 1'b1 && psel && penable && !pwrite) begin
         n = expq.pop_front();
         check("read", prdata & n[63:32], n[31:0]);
      end
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100us;
      fail_count++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      void'($urandom(3));
      s = $urandom % 256;
      pw = {$urandom, $urandom};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(FSP_STAT_OFS, 32'h0000_0009, 32'h0000_0008);
      rd(FSP_CFG_OFS, 32'h0000_0007, 32'h0000_0007);
      rd(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
      pchk(s, 1'b0);
      cmd(FSP_OP_DBWRITE, 2'h0, s);
      pchk(s, 1'b1);
      cmd(FSP_OP_DBWRITE, 2'h1, s);
      pchk(s, 1'b0);
      wr(FSP_RANGE_OFS, {s[15:0], 16'h0001});
      pchk(s, 1'b1);
      wr(FSP_RANGE_OFS, {s[15:0], 16'h0000});
      $display("test dynamic done");
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_PBPROG, 2'h0, s);
      pchk(s, 1'b1);
      cmd(FSP_OP_PBREAD, 2'h0, s);
      rd(FSP_RDATA_OFS, 32'h0000_0001, 32'h0000_0000);
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_PBERASE, 2'h0, s);
      pchk(s, 1'b0);
      cmd(FSP_OP_LOCKCLR, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      cmd(FSP_OP_DBWRITE, 2'h0, s);
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_PBPROG, 2'h0, s);
      check("busy", {31'h0, busy}, 32'h0000_0001);
      rd(FSP_STAT_OFS, 32'h0000_000C, 32'h0000_0004);
      cmd(FSP_OP_SWRST, 2'h0, 0);
      pchk(s, 1'b0);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      // Unlock with no mode selected must leave the lock cleared
      cmd(FSP_OP_UNLOCK, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      cmd(FSP_OP_HWRST, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_000F, 32'h0000_0008);
      $display("test lock done");
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_CFGPROG, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0005, 32'h0000_0005);
      cmd(FSP_OP_HWRST, 2'h0, 0);
      rd(FSP_CFG_OFS, 32'h0000_0007, 32'h0000_0007);
      wr(FSP_PWLO_OFS, pw[31:0]);
      wr(FSP_PWHI_OFS, pw[63:32]);
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_PWPROG, 2'h0, 0);
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      wr(FSP_CMD_OFS, {16'h0000, 10'h000, 2'h1, FSP_OP_CFGPROG});
      repeat (5) @(posedge clk);
      check("busy", {31'h0, busy}, 32'h0000_0001);
      // A reset command would abort the program, so let it finish first
      for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge clk);
      check("busy", {31'h0, busy}, 32'h0000_0000);
      cmd(FSP_OP_HWRST, 2'h0, 0);
      rd(FSP_CFG_OFS, 32'h0000_0007, 32'h0000_0003);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      cmd(FSP_OP_WR_ENABLE, 2'h0, 0);
      cmd(FSP_OP_CFGPROG, 2'h2, 0);
      rd(FSP_STAT_OFS, 32'h0000_0005, 32'h0000_0005);
      cmd(FSP_OP_HWRST, 2'h0, 0);
      rd(FSP_CFG_OFS, 32'h0000_0007, 32'h0000_0003);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      $display("test mode done");
      wr(FSP_PWLO_OFS, ~pw[31:0]);
      wr(FSP_CMD_OFS, {16'h0000, 10'h000, 2'h0, FSP_OP_UNLOCK});
      repeat (30) @(posedge clk);
      rd(FSP_STAT_OFS, 32'h0000_000D, 32'h0000_0005);
      // Correct password inside the spacing window is still refused
      wr(FSP_PWLO_OFS, pw[31:0]);
      cmd(FSP_OP_UNLOCK, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      cmd(FSP_OP_UNLOCK, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0009, 32'h0000_0008);
      cmd(FSP_OP_LOCKCLR, 2'h0, 0);
      rd(FSP_STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      $display("test password done");
      conclude();
   end
endmodule // tb
bind fsp_top fsp_top_asserts #(.SECTORS(SECTORS)) u_fsp_top_asserts (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .sector_protected_out(sector_protected_out),
   .busy_out(busy_out));
